//--- shared/cfp_regs.svh
`ifndef CFP_REGS_SVH
`define CFP_REGS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CFP_ADDR_W 7
`define CFP_OFS_DATA 7'h14
`define CFP_OFS_SEL 7'h20
`define CFP_OFS_CTR 7'h22
// ----------------------------------------
// Select register fields
// ----------------------------------------
`define CFP_BIT_READ_COUNT_MODE 15
`define CFP_BIT_REW 14
`define CFP_BIT_MBW 10
`define CFP_BIT_BYTE_ORDER_SELECT 8
`define CFP_BIT_CONTROL_PIPE_DIRECTION 5
`define CFP_PIPE_LO 0
`define CFP_PIPE_HI 3
`define CFP_SEL_MASK 16'hC52F
`define CFP_SEL_RESET 16'h0000
`define CFP_PIPE_DCP 4'h0
`define CFP_PIPE_MAX 4'h9
// ----------------------------------------
// Control register fields and sizes
// ----------------------------------------
`define CFP_BIT_PORT_READY_FLAG 15
`define CFP_LEN_W 10
`define CFP_NPIPE 10
`define CFP_PTR_W 10
`endif

//--- shared/cfp_pkg.sv
`default_nettype none
package cfp_pkg;
  typedef struct packed {
    logic rd;
    logic wr_lo;
    logic wr_hi;
    logic [6:0] addr;
    logic [15:0] wdata;
  } cfp_bus_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] pipe;
    logic [9:0] ptr;
    logic [15:0] wdata;
    logic two;
  } cfp_mem_t;
  typedef enum logic [1:0] {
    CFP_W8 = 2'b01,
    CFP_W16 = 2'b10
  } cfp_width_t;
endpackage
`default_nettype wire

//--- hw/cfp_lane.sv
`timescale 1ns/10ps
`default_nettype none
// Byte lane steering between the host bus and buffer byte order
module cfp_lane (
  input wire logic wide_i,
  input wire logic big_i,
  input wire logic [15:0] mem_i,
  input wire logic [15:0] bus_i,
  output logic [15:0] rd_o,
  output logic [15:0] wr_o
);
  always_comb begin
    if (!wide_i) begin
      rd_o = big_i ? {mem_i[7:0], 8'h00} : {8'h00, mem_i[7:0]};
      wr_o = big_i ? {8'h00, bus_i[15:8]} : {8'h00, bus_i[7:0]};
    end else if (big_i) begin
      rd_o = {mem_i[7:0], mem_i[15:8]};
      wr_o = {bus_i[7:0], bus_i[15:8]};
    end else begin
      rd_o = mem_i;
      wr_o = bus_i;
    end
  end
endmodule
`default_nettype wire

//--- hw/cfp_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "cfp_regs.svh"
// Operation
// - 8-bit width reads return only the first byte on the endian lane.
// - 8-bit width write with both strobes stores first byte only.
// - 8-bit width write with low strobe alone stores that byte if little-endian.
// - 16-bit width moves two bytes per read or two-strobe write, one byte per lone-strobe write.
// - Read-count mode 0 clears received length once buffer fully read.
// - Read-count mode 1 decrements received length on each read.
// - Rewind write while port ready resets the read pointer to the buffer start.
// - Rewind bit self-clears and always reads zero.
// - Width field: 0 is 8-bit access, 1 is 16-bit access.
// - Odd final transmit byte uses low strobe if little, high if big.
// - Byte order field: 0 little-endian, 1 big-endian lanes.
// - Control pipe direction: 0 reads buffer, 1 writes buffer.
// - Changing direction or pipe keeps each access position reached.
// - Pipe code 0 is control pipe, codes 1 to 9 pipes 1-9.
// - Lane placement follows width and byte order table.
// - Data register used only while port ready.
module cfp_port (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire cfp_pkg::cfp_bus_t bus_i,
  input wire logic [15:0] mem_rdata_i,
  input wire logic port_ready_flag_i,
  input wire logic [9:0] rx_len_i,
  input wire logic rx_len_load_i,
  output var cfp_pkg::cfp_mem_t mem_o,
  output logic [15:0] rdata_o,
  output logic [15:0] control_port_pipe_select_o,
  output logic [9:0] received_length_count_o
);
  import cfp_pkg::*;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] o);
    hit = (a == o);
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] sel;
  logic [15:0] next_sel;
  logic [9:0] len;
  logic [9:0] next_len;
  logic [9:0] ptr [`CFP_NPIPE];
  logic [9:0] next_ptr [`CFP_NPIPE];
  logic [15:0] rdata;
  logic [15:0] next_rdata;
  cfp_mem_t mem;
  cfp_mem_t next_mem;
  logic [15:0] lane_rd;
  logic [15:0] lane_wr;

  logic [3:0] pipe;
  logic wide;
  logic big;
  logic dir_wr;
  logic data_rd;
  logic data_wr;
  logic byte_wr_big;
  logic [9:0] step;
  logic [10:0] reach;

  assign pipe = sel[`CFP_PIPE_HI:`CFP_PIPE_LO];
  assign wide = sel[`CFP_BIT_MBW];
  assign big = sel[`CFP_BIT_BYTE_ORDER_SELECT];
  // Only the control pipe is steered by the direction bit
  assign dir_wr = (pipe == `CFP_PIPE_DCP) ? sel[`CFP_BIT_CONTROL_PIPE_DIRECTION] : 1'b1;
  // Ready gate; accesses while not ready are dropped, not stalled
  assign data_rd = bus_i.rd && hit(bus_i.addr, `CFP_OFS_DATA)
    && port_ready_flag_i && !(pipe == `CFP_PIPE_DCP && dir_wr);
  assign data_wr = (bus_i.wr_lo || bus_i.wr_hi)
    && hit(bus_i.addr, `CFP_OFS_DATA) && port_ready_flag_i && dir_wr;
  // Lone high strobe in big-endian wide mode carries the last byte
  assign byte_wr_big = wide && big && bus_i.wr_hi && !bus_i.wr_lo;
  assign step = (wide && (bus_i.wr_lo == bus_i.wr_hi || bus_i.rd))
    ? 10'h002 : 10'h001;
  // Bytes consumed once this read lands; one bit wider to avoid wrap
  assign reach = {1'b0, ptr[pipe]} + {1'b0, step};

  cfp_lane u_lane (
    .wide_i(wide),
    .big_i(big || byte_wr_big),
    .mem_i(mem_rdata_i),
    .bus_i(bus_i.wdata),
    .rd_o(lane_rd),
    .wr_o(lane_wr)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_sel = sel;
    next_len = len;
    next_rdata = rdata;
    next_mem = '0;
    next_mem.pipe = pipe;
    next_mem.ptr = ptr[pipe];
    for (int i = 0; i < `CFP_NPIPE; i++) begin
      next_ptr[i] = ptr[i];
    end
    next_sel[`CFP_BIT_REW] = 1'b0;
    if ((bus_i.wr_lo || bus_i.wr_hi) && hit(bus_i.addr, `CFP_OFS_SEL)) begin
      // Pointers live per pipe, so a switch keeps progress
      next_sel = bus_i.wdata & `CFP_SEL_MASK;
      if (bus_i.wdata[`CFP_PIPE_HI:`CFP_PIPE_LO] > `CFP_PIPE_MAX) begin
        next_sel[`CFP_PIPE_HI:`CFP_PIPE_LO] = pipe;
      end
      if (bus_i.wdata[`CFP_BIT_REW] && port_ready_flag_i) begin
        next_ptr[pipe] = 10'h000;
      end
      // Cleared even when the rewind is refused, so it never reads back
      next_sel[`CFP_BIT_REW] = 1'b0;
    end
    if (data_rd) begin
      next_mem.rd = 1'b1;
      next_mem.two = wide;
      next_ptr[pipe] = ptr[pipe] + step;
      next_rdata = lane_rd;
      if (sel[`CFP_BIT_READ_COUNT_MODE]) begin
        next_len = (len > step) ? len - step : 10'h000;
      end else if (reach >= {1'b0, len}) begin
        next_len = 10'h000;
      end
    end
    // A new packet length wins over a read in the same cycle
    if (rx_len_load_i) begin
      next_len = rx_len_i;
    end
    if (data_wr) begin
      next_mem.wr = 1'b1;
      next_mem.wdata = lane_wr;
      next_mem.two = (step == 10'h002);
      next_ptr[pipe] = ptr[pipe] + step;
    end
    if (bus_i.rd && hit(bus_i.addr, `CFP_OFS_SEL)) begin
      next_rdata = sel & `CFP_SEL_MASK & ~(16'h0001 << `CFP_BIT_REW);
    end else if (bus_i.rd && hit(bus_i.addr, `CFP_OFS_CTR)) begin
      next_rdata = {port_ready_flag_i, 5'h00, len};
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sel <= `CFP_SEL_RESET;
      len <= 10'h000;
      rdata <= 16'h0000;
      mem <= '0;
      for (int i = 0; i < `CFP_NPIPE; i++) begin
        ptr[i] <= 10'h000;
      end
    end else if (ce_i) begin
      sel <= next_sel;
      len <= next_len;
      rdata <= next_rdata;
      mem <= next_mem;
      for (int i = 0; i < `CFP_NPIPE; i++) begin
        ptr[i] <= next_ptr[i];
      end
    end
  end

  assign mem_o = mem;
  assign rdata_o = rdata;
  assign control_port_pipe_select_o = sel;
  assign received_length_count_o = len;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_rew_self_clr: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i |=> !sel[`CFP_BIT_REW]) else $error("rewind bit stayed set");
  a_unused_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    (sel & ~`CFP_SEL_MASK) == 16'h0000) else $error("unassigned bit set");
  a_narrow_rd: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && data_rd && !wide && !big |=> rdata[15:8] == 8'h00)
    else $error("narrow read high lane not zero");
  a_narrow_wr: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && data_wr && !wide |=> !mem.two && mem.wr)
    else $error("narrow write stored two bytes");
  a_wide_step: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && data_rd && wide |=> mem.two && mem.rd)
    else $error("wide read moved one byte");
  a_len_dec: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && data_rd && sel[`CFP_BIT_READ_COUNT_MODE] && !rx_len_load_i && len > 10'h002
    |=> len == $past(len) - $past(step)) else $error("length not counted");
  a_len_clr: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && data_rd && !sel[`CFP_BIT_READ_COUNT_MODE] && !rx_len_load_i
    && reach >= {1'b0, len}
    |=> len == 10'h000) else $error("length not cleared");
  a_pipe_range: assert property (@(posedge clock_i) disable iff (rst_i)
    pipe <= `CFP_PIPE_MAX) else $error("pipe code out of range");
  a_rew_ptr: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && (bus_i.wr_lo || bus_i.wr_hi) && hit(bus_i.addr, `CFP_OFS_SEL)
    && bus_i.wdata[`CFP_BIT_REW] && port_ready_flag_i
    && bus_i.wdata[`CFP_PIPE_HI:`CFP_PIPE_LO] == pipe
    |=> ptr[pipe] == 10'h000) else $error("rewind left pointer set");
  a_dir_block: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && pipe == `CFP_PIPE_DCP && !sel[`CFP_BIT_CONTROL_PIPE_DIRECTION]
    && (bus_i.wr_lo || bus_i.wr_hi) && hit(bus_i.addr, `CFP_OFS_DATA)
    |=> !mem.wr) else $error("write taken in read direction");
  a_ready_gate: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && !port_ready_flag_i |=> !mem.rd && !mem.wr)
    else $error("data access taken while not ready");
  a_sel_rdback: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && bus_i.rd && hit(bus_i.addr, `CFP_OFS_SEL)
    |=> (rdata & ~`CFP_SEL_MASK) == 16'h0000 && !rdata[`CFP_BIT_REW])
    else $error("select readback shows unassigned or rewind bit");
  a_wide_wr: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && data_wr && wide && bus_i.wr_lo && bus_i.wr_hi
    |=> mem.two && mem.wr) else $error("wide write moved one byte");
  a_big_lane: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && data_rd && !wide && big |=> rdata[7:0] == 8'h00)
    else $error("narrow big-endian read low lane not zero");
endmodule
`default_nettype wire

//--- test/cfp_buf_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Buffer memory stand-in
// ----------------------------------------
// Fixed word: N+0 is 11h, N+1 is 22h, so lane checks stay simple
module cfp_buf_model (
  input wire cfp_pkg::cfp_mem_t mem_i,
  output logic [15:0] mem_rdata_o
);
  import cfp_pkg::*;
  parameter logic [15:0] FILL = 16'h2211;
  assign mem_rdata_o = FILL;
endmodule
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cfp_pkg::*;
  logic clock_i, rst_i, ce_i, rdy, ld;
  logic [9:0] len_in, len;
  logic [15:0] mrd, rdata, sel;
  cfp_bus_t bus;
  cfp_mem_t mem;
  int error_cnt, n_compared;
  logic [15:0] er[4] = '{16'h0011, 16'h1100, 16'h2211, 16'h1122};
  logic [15:0] ew[4] = '{16'h00AA, 16'h00BB, 16'hBBAA, 16'hAABB};
  logic [15:0] mk[4] = '{16'h00FF, 16'hFF00, 16'hFFFF, 16'hFFFF};
  logic [15:0] wk[4] = '{16'h00FF, 16'h00FF, 16'hFFFF, 16'hFFFF};
  cfp_port dut_u (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
    .bus_i(bus), .mem_rdata_i(mrd), .port_ready_flag_i(rdy),
    .rx_len_i(len_in), .rx_len_load_i(ld), .mem_o(mem), .rdata_o(rdata),
    .control_port_pipe_select_o(sel), .received_length_count_o(len));
  cfp_buf_model mem_u (.mem_i(mem), .mem_rdata_o(mrd));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Odd data addresses are never used
  task automatic acc(input logic r, input logic lo, input logic hi,
      input logic [6:0] a, input logic [15:0] d);
    @(negedge clock_i);
    bus = '{rd: r, wr_lo: lo, wr_hi: hi, addr: a, wdata: d};
    @(negedge clock_i);
    bus = '0;
  endtask
  task automatic wsel(input logic [15:0] d);
    acc(1'b0, 1'b1, 1'b1, 7'h20, d);
  endtask
  task automatic rd();
    acc(1'b1, 1'b0, 1'b0, 7'h14, 16'h0000);
  endtask
  task automatic rreg(input logic [6:0] a);
    acc(1'b1, 1'b0, 1'b0, a, 16'h0000);
  endtask
  task automatic wr(input logic lo, input logic hi);
    acc(1'b0, lo, hi, 7'h14, 16'hBBAA);
  endtask
  task automatic load(input logic [9:0] n);
    @(negedge clock_i);
    ld = 1'b1;
    len_in = n;
    @(negedge clock_i);
    ld = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    rdy = 1'b1;
    ld = 1'b0;
    len_in = '0;
    bus = '0;
    error_cnt = 0;
    n_compared = 0;
    repeat (3) @(negedge clock_i);
    rst_i = 1'b0;
    chk(sel, 16'h0000);
    wsel(16'hFFFF);
    chk(sel, 16'h8520);
    wsel(16'h0409);
    chk(sel, 16'h0409);
    wsel(16'h000A);
    chk(sel, 16'h0009);
    for (int i = 0; i < 4; i++) begin
      wsel(16'h0001 | (i[1] ? 16'h0400 : 16'h0) | (i[0] ? 16'h0100 : 16'h0));
      rd();
      chk(rdata & mk[i], er[i]);
      wr(1'b1, 1'b1);
      chk(mem.wdata & wk[i], ew[i]);
      chk({14'h0, mem.wr, mem.two}, {14'h0, 1'b1, i[1]});
    end
    wr(1'b0, 1'b1);
    chk({mem.two, 7'h0, mem.wdata[7:0]}, 16'h00BB);
    wsel(16'h0001);
    wr(1'b1, 1'b0);
    chk({mem.two, 7'h0, mem.wdata[7:0]}, 16'h00AA);
    rdy = 1'b0;
    wr(1'b1, 1'b1);
    chk({15'h0, mem.wr}, 16'h0000);
    rdy = 1'b1;
    wsel(16'h0000);
    wr(1'b1, 1'b1);
    chk({15'h0, mem.wr}, 16'h0000);
    rd();
    chk({15'h0, mem.rd}, 16'h0001);
    wsel(16'h0020);
    rreg(7'h20);
    chk(rdata, 16'h0020);
    wr(1'b1, 1'b1);
    chk({15'h0, mem.wr}, 16'h0001);
    wsel(16'h0403);
    rd();
    rd();
    chk({6'h0, mem.ptr}, 16'h0002);
    wsel(16'h4403);
    chk(sel, 16'h0403);
    rreg(7'h20);
    chk(rdata, 16'h0403);
    rd();
    chk({6'h0, mem.ptr}, 16'h0000);
    rd();
    wsel(16'h0404);
    rreg(7'h20);
    chk(rdata, 16'h0404);
    rd();
    chk({12'h0, mem.pipe}, 16'h0004);
    wsel(16'h0403);
    rd();
    chk({6'h0, mem.ptr}, 16'h0004);
    ce_i = 1'b0;
    rd();
    chk({6'h0, mem.ptr}, 16'h0004);
    ce_i = 1'b1;
    rd();
    chk({6'h0, mem.ptr}, 16'h0006);
    wsel(16'h0402);
    load(10'h003);
    rd();
    chk({6'h0, len}, 16'h0003);
    rd();
    chk({6'h0, len}, 16'h0000);
    wsel(16'h8402);
    load(10'h005);
    rd();
    chk({6'h0, len}, 16'h0003);
    rreg(7'h22);
    chk(rdata, 16'h8003);
    report_and_stop();
  end
endmodule
`default_nettype wire
